//--- src/timer8_pkg.sv
package timer8_pkg;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
    localparam logic [7:0] ADDR_CTRL_C    = 8'h08;
    localparam logic [7:0] ADDR_COUNT     = 8'h0c;
    localparam logic [7:0] ADDR_CMP_A     = 8'h10;
    localparam logic [7:0] ADDR_CMP_B     = 8'h14;
    localparam logic [7:0] ADDR_FLAGS     = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
    localparam logic [7:0] ADDR_PORT_OUT  = 8'h20;
    localparam logic [7:0] ADDR_PORT_DIR  = 8'h24;

    // Control A fields
    localparam int COM_A_LSB  = 6;
    localparam int COM_B_LSB  = 4;
    localparam int WGM_LO_LSB = 0;
    // Control B fields
    localparam int WGM_HI_BIT = 3;
    localparam int CS_LSB     = 0;
    // Control C strobes
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    // Flag and mask bit positions
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    // Port bit positions for the two wave outputs
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;

    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [2:0] CS_STOPPED   = 3'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'h0,
        WGM_PC_MAX   = 3'h1,
        WGM_CTC      = 3'h2,
        WGM_FAST_MAX = 3'h3,
        WGM_RSV4     = 3'h4,
        WGM_PC_OCRA  = 3'h5,
        WGM_RSV6     = 3'h6,
        WGM_FAST_OCRA = 3'h7
    } wgm_t;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

endpackage : timer8_pkg

//--- src/timer8_counter_compare.sv
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
// How it works
// - Clock select field picks tick source; zero stops the timer.
// - Each tick clears, increments or decrements the counter per mode.
// - Counter register readable and writable at any time.
// - Software counter write beats a same-cycle clear or count.
// - Mode field: two low bits in control A, high bit in control B.
// - Overflow flag set at mode-defined points; may request interrupt.
// - Counter compared with both compare values continuously.
// - Match sets channel flag on following tick; interrupt if enabled.
// - Flag clears on interrupt service or by writing one.
// - PWM modes: compare writes buffered, loaded at top or bottom.
// - Normal and CTC modes: compare writes go straight to active value.
// - Non-PWM force strobe acts like a match, no flag, no counter change.
// - Counter write blocks compare matches on the next tick, even stopped.
// - Output mode change unbuffered; acts on next match or force.
// - Reset clears both output state registers.
// - Nonzero output mode overrides port value; direction from port register.
// - Output mode zero leaves output state untouched on match.
// - Non-PWM: set, clear, toggle; PWM: inverted or non-inverted, plus A toggle in modes 5/7.
// - Output mode never affects the counting sequence.
// - Output states kept across waveform mode changes.
// - Top and bottom indications handle extreme compare values.
// - Modes: 0 normal, 2 CTC, 3/7 fast, 1/5 phase-correct; 5/7 top is A.
// - Normal: count up, wrap from max to zero, flag overflow on wrap.
module timer8_counter_compare
    import timer8_pkg::*;
#(
    parameter int PRESCALE_W = 10
) (
    // Clock and reset
    input  wire  logic        hclk,
    input  wire  logic        hresetn,
    // AHB-Lite slave
    input  wire  logic        hsel,
    input  wire  logic [7:0]  haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // External tick source pin
    input  wire  logic        ext_clk_pin,
    // Interrupt service acknowledges from the processor
    input  wire  logic        ack_overflow,
    input  wire  logic        ack_match_a,
    input  wire  logic        ack_match_b,
    // Interrupt requests
    output logic              irq_overflow,
    output logic              irq_match_a,
    output logic              irq_match_b,
    // Wave output pins
    output logic              wave_output_a,
    output logic              wave_output_a_oe,
    output logic              wave_output_b,
    output logic              wave_output_b_oe
);
    import timer8_pkg::*;

    initial begin
        if (PRESCALE_W < 10) $error("PRESCALE_W must be at least 10");
    end

    logic [7:0] ctrl_a_ff, ctrl_b_ff, count_value_reg_ff;
    logic [7:0] compare_value_a_ff, compare_value_b_ff, buf_a_ff, buf_b_ff;
    logic [2:0] flags_ff, mask_ff;
    logic [1:0] port_out_ff, port_dir_ff;
    logic       oc_a_ff, oc_b_ff, block_ff, up_ff;
    logic [PRESCALE_W-1:0] pre_ff;
    logic [2:0] ext_sync_ff;
    logic       wr_pend_ff;
    logic [7:0] wr_addr_ff;

    // Bus decode: zero wait states, always OKAY
    wire        addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire [31:0] wdata      = hwdata;
    wire        wr_ctrl_a  = wr_pend_ff && wr_addr_ff == ADDR_CTRL_A;
    wire        wr_ctrl_b  = wr_pend_ff && wr_addr_ff == ADDR_CTRL_B;
    wire        wr_ctrl_c  = wr_pend_ff && wr_addr_ff == ADDR_CTRL_C;
    wire        wr_count   = wr_pend_ff && wr_addr_ff == ADDR_COUNT;
    wire        wr_cmp_a   = wr_pend_ff && wr_addr_ff == ADDR_CMP_A;
    wire        wr_cmp_b   = wr_pend_ff && wr_addr_ff == ADDR_CMP_B;
    wire        wr_flags   = wr_pend_ff && wr_addr_ff == ADDR_FLAGS;
    wire        wr_mask    = wr_pend_ff && wr_addr_ff == ADDR_IRQ_MASK;
    wire        wr_pout    = wr_pend_ff && wr_addr_ff == ADDR_PORT_OUT;
    wire        wr_pdir    = wr_pend_ff && wr_addr_ff == ADDR_PORT_DIR;

    // Mode decode
    wire [2:0] wgm      = {ctrl_b_ff[WGM_HI_BIT], ctrl_a_ff[WGM_LO_LSB +: 2]};
    wire [2:0] cs       = ctrl_b_ff[CS_LSB +: 3];
    wire [1:0] com_a    = ctrl_a_ff[COM_A_LSB +: 2];
    wire [1:0] com_b    = ctrl_a_ff[COM_B_LSB +: 2];
    wire       is_fast  = wgm == WGM_FAST_MAX || wgm == WGM_FAST_OCRA;
    wire       is_pc    = wgm == WGM_PC_MAX || wgm == WGM_PC_OCRA;
    wire       is_pwm   = is_fast || is_pc;
    wire       is_ctc   = wgm == WGM_CTC;
    wire       top_a    = wgm == WGM_PC_OCRA || wgm == WGM_FAST_OCRA || is_ctc;
    wire [7:0] top_val  = top_a ? compare_value_a_ff : COUNT_MAX;

    // Tick generation: prescaler taps and synchronised external edges
    wire ext_rise = ext_sync_ff[1] && !ext_sync_ff[2];
    wire ext_fall = !ext_sync_ff[1] && ext_sync_ff[2];
    logic tick;
    always_comb begin
        unique case (cs)
            3'h0:    tick = 1'b0;
            3'h1:    tick = 1'b1;
            3'h2:    tick = &pre_ff[2:0];
            3'h3:    tick = &pre_ff[5:0];
            3'h4:    tick = &pre_ff[7:0];
            3'h5:    tick = &pre_ff[9:0];
            3'h6:    tick = ext_fall;
            default: tick = ext_rise;
        endcase
    end

    // Counter unit
    wire       at_top    = count_value_reg_ff == top_val;
    wire       at_bottom = count_value_reg_ff == COUNT_BOTTOM;
    wire       match_a   = count_value_reg_ff == compare_value_a_ff;
    wire       match_b   = count_value_reg_ff == compare_value_b_ff;
    wire       fire_a    = tick && match_a && !block_ff;
    wire       fire_b    = tick && match_b && !block_ff;
    wire       clear_cnt = (is_ctc || is_fast) && at_top;
    wire       nxt_up    = is_pc ? (at_top ? 1'b0 : (at_bottom ? 1'b1 : up_ff)) : 1'b1;
    logic [7:0] nxt_count;
    always_comb begin
        if (clear_cnt)   nxt_count = COUNT_BOTTOM;
        else if (nxt_up) nxt_count = count_value_reg_ff + 8'h01;
        else             nxt_count = count_value_reg_ff - 8'h01;
    end
    // Overflow: count at max in normal/CTC, top in fast, bottom in phase-correct
    wire ovf_evt = tick && (is_fast ? at_top
                          : is_pc ? at_bottom && !up_ff
                          : count_value_reg_ff == COUNT_MAX);
    wire load_buf = tick && (is_fast ? at_bottom : (is_pc && at_top));

    // Output compare action
    function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                     input logic pwm, input logic up,
                                     input logic allow_toggle);
        if (com == COM_OFF) return cur;
        if (!pwm) begin
            unique case (com)
                COM_TOGGLE: return !cur;
                COM_CLEAR:  return 1'b0;
                default:    return 1'b1;
            endcase
        end
        if (com == COM_TOGGLE) return allow_toggle ? !cur : cur;
        return (com == COM_SET) ? up : !up;
    endfunction : oc_next

    wire force_a = wr_ctrl_c && wdata[FORCE_A_BIT] && !is_pwm;
    wire force_b = wr_ctrl_c && wdata[FORCE_B_BIT] && !is_pwm;
    wire ph_up   = is_fast ? 1'b1 : up_ff;
    wire tog_ok  = wgm[2];
    wire fast_bottom = tick && is_fast && clear_cnt;
    logic nxt_oc_a, nxt_oc_b;
    always_comb begin
        nxt_oc_a = oc_a_ff;
        nxt_oc_b = oc_b_ff;
        if (fast_bottom && com_a[1]) nxt_oc_a = !com_a[0];
        if (fast_bottom && com_b[1]) nxt_oc_b = !com_b[0];
        if (fire_a || force_a) nxt_oc_a = oc_next(oc_a_ff, com_a, is_pwm, ph_up, tog_ok);
        if (fire_b || force_b) nxt_oc_b = oc_next(oc_b_ff, com_b, is_pwm, ph_up, 1'b0);
    end

    wire [2:0] evts = {fire_b, fire_a, ovf_evt};
    wire [2:0] acks = {ack_match_b, ack_match_a, ack_overflow};
    wire [2:0] sw_clr = wr_flags ? wdata[2:0] : 3'h0;
    wire [2:0] nxt_flags = evts | (flags_ff & ~(acks | sw_clr));

    // Read mux
    wire [7:0] cmp_a_view = is_pwm ? buf_a_ff : compare_value_a_ff;
    wire [7:0] cmp_b_view = is_pwm ? buf_b_ff : compare_value_b_ff;
    logic [7:0] rd_byte;
    always_comb begin
        unique case (haddr)
            ADDR_CTRL_A:   rd_byte = ctrl_a_ff;
            ADDR_CTRL_B:   rd_byte = ctrl_b_ff;
            ADDR_COUNT:    rd_byte = count_value_reg_ff;
            ADDR_CMP_A:    rd_byte = cmp_a_view;
            ADDR_CMP_B:    rd_byte = cmp_b_view;
            ADDR_FLAGS:    rd_byte = {5'h00, flags_ff};
            ADDR_IRQ_MASK: rd_byte = {5'h00, mask_ff};
            ADDR_PORT_OUT: rd_byte = {6'h00, port_out_ff};
            ADDR_PORT_DIR: rd_byte = {6'h00, port_dir_ff};
            default:       rd_byte = RESET_BYTE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= RESET_BYTE;
            hrdata     <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= haddr;
            hrdata     <= (addr_phase && !hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync_ff <= 3'h0;
            pre_ff      <= '0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[1:0], ext_clk_pin};
            pre_ff      <= (cs == CS_STOPPED) ? pre_ff : pre_ff + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_a_ff   <= RESET_BYTE;
            ctrl_b_ff   <= RESET_BYTE;
            mask_ff     <= 3'h0;
            port_out_ff <= 2'h0;
            port_dir_ff <= 2'h0;
        end else begin
            if (wr_ctrl_a) ctrl_a_ff   <= wdata[7:0];
            if (wr_ctrl_b) ctrl_b_ff   <= wdata[7:0];
            if (wr_mask)   mask_ff     <= wdata[2:0];
            if (wr_pout)   port_out_ff <= wdata[1:0];
            if (wr_pdir)   port_dir_ff <= wdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value_reg_ff <= COUNT_BOTTOM;
            up_ff              <= 1'b1;
            block_ff           <= 1'b0;
        end else begin
            if (wr_count) count_value_reg_ff <= wdata[7:0];
            else if (tick) count_value_reg_ff <= nxt_count;
            if (tick) up_ff <= nxt_up;
            // Block stays armed until a tick consumes it
            if (wr_count) block_ff <= 1'b1;
            else if (tick) block_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_value_a_ff <= RESET_BYTE;
            compare_value_b_ff <= RESET_BYTE;
            buf_a_ff           <= RESET_BYTE;
            buf_b_ff           <= RESET_BYTE;
        end else begin
            if (wr_cmp_a) buf_a_ff <= wdata[7:0];
            if (wr_cmp_b) buf_b_ff <= wdata[7:0];
            if (wr_cmp_a && !is_pwm) compare_value_a_ff <= wdata[7:0];
            else if (load_buf) compare_value_a_ff <= buf_a_ff;
            if (wr_cmp_b && !is_pwm) compare_value_b_ff <= wdata[7:0];
            else if (load_buf) compare_value_b_ff <= buf_b_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_ff <= 3'h0;
            oc_a_ff  <= 1'b0;
            oc_b_ff  <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            oc_a_ff  <= nxt_oc_a;
            oc_b_ff  <= nxt_oc_b;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign irq_overflow = flags_ff[FLAG_OVF] && mask_ff[FLAG_OVF];
    assign irq_match_a  = flags_ff[FLAG_CMPA] && mask_ff[FLAG_CMPA];
    assign irq_match_b  = flags_ff[FLAG_CMPB] && mask_ff[FLAG_CMPB];

    assign wave_output_a    = (com_a != COM_OFF) ? oc_a_ff : port_out_ff[PIN_A];
    assign wave_output_b    = (com_b != COM_OFF) ? oc_b_ff : port_out_ff[PIN_B];
    assign wave_output_a_oe = port_dir_ff[PIN_A];
    assign wave_output_b_oe = port_dir_ff[PIN_B];

endmodule : timer8_counter_compare

//--- test/timer8_counter_compare_monitor.sv
`timescale 1ns/100ps
module timer8_counter_compare_monitor
    import timer8_pkg::*;
(
    // Clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Interrupt A and pins
    input wire logic        ack_match_a,
    input wire logic        irq_match_a,
    input wire logic        wave_output_a,
    input wire logic        wave_output_a_oe,
    input wire logic        wave_output_b
);
    // Shadows of the written control state, updated when the write lands
    logic       wr_ff, rd_ff;
    logic [7:0] addr_ff, ctrl_a_ff, ctrl_b_ff, pout_ff, dir_ff;
    wire        take     = hsel && hready && htrans[1];
    wire  [1:0] com_a    = ctrl_a_ff[COM_A_LSB +: 2];
    wire  [1:0] com_b    = ctrl_a_ff[COM_B_LSB +: 2];
    wire  [2:0] wgm      = {ctrl_b_ff[WGM_HI_BIT], ctrl_a_ff[1:0]};
    wire        stopped  = ctrl_b_ff[2:0] == CS_STOPPED;
    wire        non_pwm  = wgm == WGM_NORMAL || wgm == WGM_CTC;
    wire        force_a  = wr_ff && addr_ff == ADDR_CTRL_C && hwdata[FORCE_A_BIT];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_ff, rd_ff, addr_ff, ctrl_a_ff, ctrl_b_ff, pout_ff, dir_ff} <= '0;
        end else begin
            wr_ff   <= take && hwrite;
            rd_ff   <= take && !hwrite;
            addr_ff <= haddr;
            if (wr_ff && addr_ff == ADDR_CTRL_A) ctrl_a_ff <= hwdata[7:0];
            if (wr_ff && addr_ff == ADDR_CTRL_B) ctrl_b_ff <= hwdata[7:0];
            if (wr_ff && addr_ff == ADDR_PORT_OUT) pout_ff <= hwdata[7:0];
            if (wr_ff && addr_ff == ADDR_PORT_DIR) dir_ff <= hwdata[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("slave not ready or error");
    AST_OE_A: assert property ($changed(wave_output_a_oe) |->
        $past(wr_ff && addr_ff == ADDR_PORT_DIR) && wave_output_a_oe == $past(hwdata[PIN_A]))
        else $error("pin A direction moved without direction write");
    AST_SRC_A: assert property (com_a == COM_OFF |-> wave_output_a == pout_ff[PIN_A])
        else $error("pin A not showing port value");
    AST_SRC_B: assert property (com_b == COM_OFF |-> wave_output_b == pout_ff[PIN_B])
        else $error("pin B not showing port value");
    AST_FORCE_A: assert property (force_a && non_pwm && stopped && $past(stopped) |=>
        wave_output_a == ($past(com_a) == COM_SET || ($past(com_a) == COM_TOGGLE &&
        !$past(wave_output_a)) || ($past(com_a) == COM_OFF && $past(wave_output_a))))
        else $error("forced compare gave wrong pin A level");
    AST_RESET_PINS: assert property ($rose(hresetn) |-> !wave_output_a && !wave_output_b)
        else $error("wave outputs not cleared by reset");
    AST_STOP_IRQ: assert property (stopped && $past(stopped) && !wr_ff && !ack_match_a
        |=> $stable(irq_match_a)) else $error("match request moved while stopped");
    AST_DIR_READ: assert property (rd_ff && addr_ff == ADDR_PORT_DIR |-> hrdata[7:0] == dir_ff)
        else $error("direction read back wrong");
    AST_UNMAPPED: assert property (rd_ff && addr_ff > ADDR_PORT_DIR |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    COV_FORCE: cover property (force_a && non_pwm);
    COV_IRQ: cover property ($rose(irq_match_a));
    COV_OE: cover property ($changed(wave_output_a_oe));
endmodule : timer8_counter_compare_monitor

bind timer8_counter_compare timer8_counter_compare_monitor u_monitor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ack_match_a(ack_match_a),
    .irq_match_a(irq_match_a), .wave_output_a(wave_output_a),
    .wave_output_a_oe(wave_output_a_oe), .wave_output_b(wave_output_b));

//--- test/timer8_counter_compare_tb.sv
`timescale 1ns/100ps
module timer8_counter_compare_tb;
    import timer8_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, ext_clk_pin;
    logic        ack_overflow, ack_match_a, ack_match_b;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    wire         hready;
    logic        hreadyout, hresp, irq_overflow, irq_match_a, irq_match_b;
    logic        wave_output_a, wave_output_a_oe, wave_output_b, wave_output_b_oe;
    int          mismatches, total_checks, cycles;
    assign hready = hreadyout;
    timer8_counter_compare #(.PRESCALE_W(10)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_clk_pin(ext_clk_pin),
        .ack_overflow(ack_overflow), .ack_match_a(ack_match_a), .ack_match_b(ack_match_b),
        .irq_overflow(irq_overflow), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
        .wave_output_a(wave_output_a), .wave_output_a_oe(wave_output_a_oe),
        .wave_output_b(wave_output_b), .wave_output_b_oe(wave_output_b_oe));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task end_of_test;
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // Whole run is well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(what, exp, rd);
    endtask : rdc
    // Timer on at full rate for a short burst, then stopped again
    task run;
        bus(ADDR_CTRL_B, 1'b1, 32'h1);
        repeat (4) @(posedge hclk);
        bus(ADDR_CTRL_B, 1'b1, 32'h0);
    endtask : run
    task t_reset;
        check("wave a", 32'h0, {31'h0, wave_output_a});
        rdc("count", ADDR_COUNT, 32'h0);
        bus(8'h40, 1'b1, 32'ha5);
        rdc("unmapped", 8'h40, 32'h0);
    endtask : t_reset
    task t_clock_sources;
        bus(ADDR_COUNT, 1'b1, 32'h55);
        repeat (20) @(posedge hclk);
        rdc("count stopped", ADDR_COUNT, 32'h55);
        for (int cs = 7; cs >= 6; cs--) begin
            bus(ADDR_COUNT, 1'b1, 32'h0);
            bus(ADDR_CTRL_B, 1'b1, cs);
            repeat (3) begin
                ext_clk_pin <= 1'b1;
                repeat (4) @(posedge hclk);
                ext_clk_pin <= 1'b0;
                repeat (4) @(posedge hclk);
            end
            repeat (4) @(posedge hclk);
            bus(ADDR_CTRL_B, 1'b1, 32'h0);
            rdc("external count", ADDR_COUNT, 32'h3);
        end
    endtask : t_clock_sources
    task t_match;
        bus(ADDR_CMP_A, 1'b1, 32'h07);
        bus(ADDR_COUNT, 1'b1, 32'h07);
        run();
        rdc("flags blocked", ADDR_FLAGS, 32'h0);
        bus(ADDR_COUNT, 1'b1, 32'h03);
        run();
        rdc("flags match", ADDR_FLAGS, 32'h2);
        check("irq masked", 32'h0, {31'h0, irq_match_a});
        bus(ADDR_IRQ_MASK, 1'b1, 32'h2);
        @(posedge hclk);
        check("irq on", 32'h1, {31'h0, irq_match_a});
        ack_match_a <= 1'b1;
        @(posedge hclk);
        ack_match_a <= 1'b0;
        @(posedge hclk);
        check("irq serviced", 32'h0, {31'h0, irq_match_a});
        bus(ADDR_COUNT, 1'b1, 32'h03);
        run();
        bus(ADDR_FLAGS, 1'b1, 32'h2);
        rdc("flags cleared", ADDR_FLAGS, 32'h0);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
    endtask : t_match
    task t_overflow;
        bus(ADDR_CMP_A, 1'b1, 32'h80);
        bus(ADDR_COUNT, 1'b1, 32'hfd);
        run();
        rdc("wrap flags", ADDR_FLAGS, 32'h5);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h5);
        @(posedge hclk);
        check("irq ovf and b", 32'h3, {30'h0, irq_overflow, irq_match_b});
        ack_overflow <= 1'b1;
        ack_match_b  <= 1'b1;
        @(posedge hclk);
        ack_overflow <= 1'b0;
        ack_match_b  <= 1'b0;
        @(posedge hclk);
        check("irq ovf and b serviced", 32'h0, {30'h0, irq_overflow, irq_match_b});
        bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
        bus(ADDR_FLAGS, 1'b1, 32'h7);
    endtask : t_overflow
    task t_force;
        logic [7:0] ctrl [4] = '{8'h40, 8'h40, 8'hc0, 8'h00};
        logic       lvl  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        bus(ADDR_PORT_DIR, 1'b1, 32'h3);
        @(posedge hclk);
        check("pin enables", 32'h1, {31'h0, wave_output_a_oe & wave_output_b_oe});
        rdc("port dir", ADDR_PORT_DIR, 32'h3);
        bus(ADDR_COUNT, 1'b1, 32'h33);
        for (int i = 0; i < 4; i++) begin
            bus(ADDR_CTRL_A, 1'b1, {24'h0, ctrl[i]});
            bus(ADDR_CTRL_C, 1'b1, 32'h80);
            @(posedge hclk);
            check("forced a", {31'h0, lvl[i]}, {31'h0, wave_output_a});
        end
        bus(ADDR_CTRL_A, 1'b1, 32'h80);
        @(posedge hclk);
        check("state held", 32'h1, {31'h0, wave_output_a});
        bus(ADDR_CTRL_A, 1'b1, 32'h00);
        bus(ADDR_PORT_OUT, 1'b1, 32'h1);
        @(posedge hclk);
        check("port value", 32'h1, {31'h0, wave_output_a});
        bus(ADDR_CTRL_A, 1'b1, 32'h10);
        bus(ADDR_CTRL_C, 1'b1, 32'h40);
        bus(ADDR_CTRL_A, 1'b1, 32'h13);
        @(posedge hclk);
        check("forced b kept", 32'h1, {31'h0, wave_output_b});
        rdc("count kept", ADDR_COUNT, 32'h33);
        rdc("no flag", ADDR_FLAGS, 32'h0);
    endtask : t_force
    task t_buffer;
        bus(ADDR_CTRL_A, 1'b1, 32'h00);
        bus(ADDR_CMP_A, 1'b1, 32'h10);
        bus(ADDR_CTRL_A, 1'b1, 32'h03);
        bus(ADDR_CMP_A, 1'b1, 32'h20);
        bus(ADDR_COUNT, 1'b1, 32'h0e);
        run();
        rdc("old compare active", ADDR_FLAGS, 32'h2);
        rdc("compare buffer", ADDR_CMP_A, 32'h20);
    endtask : t_buffer
    // Clear-on-compare wraps at compare A; phase-correct turns at max
    task t_modes;
        bus(ADDR_FLAGS, 1'b1, 32'h7);
        bus(ADDR_CTRL_A, 1'b1, 32'h02);
        bus(ADDR_CMP_A, 1'b1, 32'h05);
        bus(ADDR_COUNT, 1'b1, 32'h00);
        run();
        rdc("ctc count", ADDR_COUNT, 32'h0);
        rdc("ctc flags", ADDR_FLAGS, 32'h2);
        bus(ADDR_FLAGS, 1'b1, 32'h7);
        bus(ADDR_CTRL_A, 1'b1, 32'h01);
        bus(ADDR_COUNT, 1'b1, 32'hfd);
        run();
        rdc("phase count", ADDR_COUNT, 32'hfb);
    endtask : t_modes
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, ext_clk_pin} = '0;
        {ack_overflow, ack_match_a, ack_match_b} = '0;
        hsize = 3'h2;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_clock_sources();
        t_match();
        t_overflow();
        t_force();
        t_buffer();
        t_modes();
        end_of_test();
    end
endmodule : timer8_counter_compare_tb
